// ---- hdl/cprm_defines.svh ----
// register map, field positions and reset values of the programmer register model
// Operation
// - The block holds sixteen 32-bit general registers, a program counter, both stack pointers, a 16-bit status word, two function code registers and a vector table base.
// - The stack alias reaches the user stack pointer at user privilege and the supervisor stack pointer at supervisor privilege.
// - At user privilege only the low condition-flag byte of the status word is reachable, at supervisor privilege all of it.
// - Copying the whole status word out at user privilege is refused as a privilege violation.
// - The status word keeps trace bits at 15 and 14, privilege at 13, priority mask at 10 to 8, flags at 4 to 0, others zero.
// - Data registers take bit, byte, word and long operands, and any two of them form a 64-bit pair.
// - Any of the sixteen general registers can be chosen as the index of an address calculation.
// - Address registers take only word and long writes and serve as stack or base pointers.
// - The program counter is either advanced or loaded anew, also on exception entry.
// - Supervisor control registers are reachable only at supervisor privilege.
`ifndef CPRM_DEFINES_SVH
`define CPRM_DEFINES_SVH

// byte offsets
`define CPRM_OFF_DATA0 8'h00
`define CPRM_OFF_ADDR0 8'h20
`define CPRM_OFF_STACK 8'h3c
`define CPRM_OFF_PC 8'h40
`define CPRM_OFF_STATUS 8'h44
`define CPRM_OFF_VBASE 8'h48
`define CPRM_OFF_SFC 8'h4c
`define CPRM_OFF_DFC 8'h50
`define CPRM_OFF_USP 8'h54
`define CPRM_OFF_PC_ADV 8'h58
`define CPRM_OFF_EXC 8'h5c
`define CPRM_OFF_INDEX_CFG 8'h60
`define CPRM_OFF_INDEX_RES 8'h64
`define CPRM_OFF_QUAD_CFG 8'h68
`define CPRM_OFF_QUAD_HI 8'h6c
`define CPRM_OFF_QUAD_LO 8'h70
`define CPRM_OFF_BIT_OP 8'h74
`define CPRM_OFF_STATUS_COPY 8'h78
`define CPRM_OFF_FAULT 8'h7c

// status word fields
`define CPRM_SW_T1 15
`define CPRM_SW_T0 14
`define CPRM_SW_S 13
`define CPRM_SW_IPM_HI 10
`define CPRM_SW_IPM_LO 8
`define CPRM_SW_Z 2
`define CPRM_STATUS_RESET 16'h2700
`define CPRM_STATUS_MASK 16'he71f
`define CPRM_FLAG_MASK 8'h1f

// general register bank
`define CPRM_NUM_GPR 17
`define CPRM_IDX_USP 5'h0f
`define CPRM_IDX_SSP 5'h10
`define CPRM_GPR_RESET 32'h0000_0000

// byte lane patterns
`define CPRM_BE_BYTE 4'h1
`define CPRM_BE_WORD 4'h3
`define CPRM_BE_LONG 4'hf

// fault register bits
`define CPRM_FAULT_PRIV 0
`define CPRM_FAULT_SIZE 1

`endif

// ---- hdl/cprm_gpr.sv ----
// one 32-bit general register with byte lane writes
`timescale 1ns/100ps
`include "cprm_defines.svh"

module cprm_gpr (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // write port
    input wire logic we,
    input wire logic [3:0] be,
    input wire logic sext,
    input wire logic [31:0] wd,
    // value
    output logic [31:0] q
);

    cprm_pkg::cprm_gpr_s st_q;
    cprm_pkg::cprm_gpr_s st_d;

    always_comb begin
        st_d = st_q;
        if (we) begin
            // without sext only written lanes change
            for (int i = 0; i < 4; i++) begin
                if (be[i]) begin
                    st_d.value[8*i +: 8] = wd[8*i +: 8];
                end
            end
            // word writes to address registers fill the upper half
            if (sext && (be == `CPRM_BE_WORD)) begin
                st_d.value[31:16] = {16{wd[15]}};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    assign q = st_q.value;

endmodule : cprm_gpr

// ---- hdl/cprm_pkg.sv ----
// types of the programmer register model
package cprm_pkg;

    typedef enum logic [4:0] {
        sel_none = 5'b00000,
        sel_data = 5'b00001,
        sel_addr = 5'b00010,
        sel_stack = 5'b00011,
        sel_pc = 5'b00100,
        sel_status = 5'b00101,
        sel_vbase = 5'b00110,
        sel_sfc = 5'b00111,
        sel_dfc = 5'b01000,
        sel_usp = 5'b01001,
        sel_pc_adv = 5'b01010,
        sel_exc = 5'b01011,
        sel_index_cfg = 5'b01100,
        sel_index_res = 5'b01101,
        sel_quad_cfg = 5'b01110,
        sel_quad_hi = 5'b01111,
        sel_quad_lo = 5'b10000,
        sel_bit_op = 5'b10001,
        sel_status_copy = 5'b10010,
        sel_fault = 5'b10011
    } cprm_sel_e;

    typedef enum logic [1:0] {
        bitop_test = 2'b00,
        bitop_change = 2'b01,
        bitop_clear = 2'b10,
        bitop_set = 2'b11
    } cprm_bitop_e;

    typedef struct packed {
        logic [31:0] value;
    } cprm_gpr_s;

    typedef struct packed {
        logic [15:0] status;
        logic [31:0] pc;
        logic [31:0] vbase;
        logic [2:0] alt_source_function_code;
        logic [2:0] dfc;
        logic [6:0] index_cfg;
        logic [6:0] quad_cfg;
        logic [9:0] bit_cfg;
        logic [1:0] fault;
        logic [31:0] rdata;
    } cprm_state_s;

endpackage : cprm_pkg

// ---- hdl/cprm_regfile.sv ----
// programmer register model behind an apb slave
`timescale 1ns/100ps
`include "cprm_defines.svh"

module cprm_regfile (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // status view
    output logic supervisor,
    output logic [2:0] interrupt_priority_mask,
    output logic [1:0] trace_mode,
    output logic [31:0] program_counter
);

    cprm_pkg::cprm_state_s st_q;
    cprm_pkg::cprm_state_s st_d;

    // register bank wiring
    logic [31:0] gpr_q [`CPRM_NUM_GPR];
    logic [`CPRM_NUM_GPR-1:0] gpr_we;
    logic [3:0] gpr_be;
    logic gpr_sext;
    logic [31:0] gpr_wd;

    // decode and access helpers
    cprm_pkg::cprm_sel_e sel;
    logic sup;
    logic setup;
    logic access;
    logic err;
    logic priv_err;
    logic size_err;
    logic [31:0] rd_val;
    logic [31:0] stack_cur;
    logic [4:0] reg_idx;
    logic [31:0] idx_src;
    logic [31:0] idx_ext;
    logic [31:0] idx_res;
    logic [4:0] bit_reg;
    logic [31:0] bit_src;
    logic [31:0] bit_mask;
    logic lanes_ok;

    function automatic cprm_pkg::cprm_sel_e decode(input logic [7:0] a);
        cprm_pkg::cprm_sel_e s;
        s = cprm_pkg::sel_none;
        if (a[1:0] != 2'b00) begin
            s = cprm_pkg::sel_none;
        end else if (a < `CPRM_OFF_ADDR0) begin
            s = cprm_pkg::sel_data;
        end else if (a < `CPRM_OFF_STACK) begin
            s = cprm_pkg::sel_addr;
        end else begin
            case (a)
                `CPRM_OFF_STACK: s = cprm_pkg::sel_stack;
                `CPRM_OFF_PC: s = cprm_pkg::sel_pc;
                `CPRM_OFF_STATUS: s = cprm_pkg::sel_status;
                `CPRM_OFF_VBASE: s = cprm_pkg::sel_vbase;
                `CPRM_OFF_SFC: s = cprm_pkg::sel_sfc;
                `CPRM_OFF_DFC: s = cprm_pkg::sel_dfc;
                `CPRM_OFF_USP: s = cprm_pkg::sel_usp;
                `CPRM_OFF_PC_ADV: s = cprm_pkg::sel_pc_adv;
                `CPRM_OFF_EXC: s = cprm_pkg::sel_exc;
                `CPRM_OFF_INDEX_CFG: s = cprm_pkg::sel_index_cfg;
                `CPRM_OFF_INDEX_RES: s = cprm_pkg::sel_index_res;
                `CPRM_OFF_QUAD_CFG: s = cprm_pkg::sel_quad_cfg;
                `CPRM_OFF_QUAD_HI: s = cprm_pkg::sel_quad_hi;
                `CPRM_OFF_QUAD_LO: s = cprm_pkg::sel_quad_lo;
                `CPRM_OFF_BIT_OP: s = cprm_pkg::sel_bit_op;
                `CPRM_OFF_STATUS_COPY: s = cprm_pkg::sel_status_copy;
                `CPRM_OFF_FAULT: s = cprm_pkg::sel_fault;
                default: s = cprm_pkg::sel_none;
            endcase
        end
        return s;
    endfunction : decode

    // data, address and both stack registers
    genvar gi;
    generate
        for (gi = 0; gi < `CPRM_NUM_GPR; gi++) begin : g_gpr
            cprm_gpr u_gpr (
                .pclk(pclk),
                .presetn(presetn),
                .ce(ce),
                .we(gpr_we[gi]),
                .be(gpr_be),
                .sext(gpr_sext),
                .wd(gpr_wd),
                .q(gpr_q[gi])
            );
        end
    endgenerate

    assign sup = st_q.status[`CPRM_SW_S];
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign sel = decode(paddr);
    assign stack_cur = sup ? gpr_q[`CPRM_IDX_SSP] : gpr_q[`CPRM_IDX_USP];
    assign reg_idx = (sel == cprm_pkg::sel_addr) ? {2'b01, paddr[4:2]} : {2'b00, paddr[4:2]};
    assign lanes_ok = (pstrb == `CPRM_BE_BYTE) || (pstrb == `CPRM_BE_WORD)
        || (pstrb == `CPRM_BE_LONG);

    // scaled index from any of the sixteen registers
    always_comb begin
        if (st_q.index_cfg[3:0] == 4'hf) begin
            idx_src = stack_cur;
        end else begin
            idx_src = gpr_q[{1'b0, st_q.index_cfg[3:0]}];
        end
        idx_ext = st_q.index_cfg[4] ? idx_src : {{16{idx_src[15]}}, idx_src[15:0]};
        idx_res = idx_ext << st_q.index_cfg[6:5];
    end

    // bit operand on a data register
    assign bit_reg = {2'b00, pwdata[2:0]};
    assign bit_src = gpr_q[bit_reg];
    assign bit_mask = 32'h0000_0001 << pwdata[7:3];

    // read value and refusal of the addressed register
    always_comb begin
        rd_val = 32'h0000_0000;
        priv_err = 1'b0;
        size_err = 1'b0;
        err = 1'b0;
        case (sel)
            cprm_pkg::sel_data: begin
                rd_val = gpr_q[reg_idx];
                size_err = pwrite && !lanes_ok;
            end
            cprm_pkg::sel_addr: begin
                rd_val = gpr_q[reg_idx];
                size_err = pwrite && (!lanes_ok || (pstrb == `CPRM_BE_BYTE));
            end
            cprm_pkg::sel_stack: begin
                rd_val = stack_cur;
                size_err = pwrite && (!lanes_ok || (pstrb == `CPRM_BE_BYTE));
            end
            cprm_pkg::sel_usp: begin
                rd_val = gpr_q[`CPRM_IDX_USP];
                priv_err = !sup;
                size_err = pwrite && (!lanes_ok || (pstrb == `CPRM_BE_BYTE));
            end
            cprm_pkg::sel_pc: rd_val = st_q.pc;
            cprm_pkg::sel_status: begin
                // user view holds the condition flag byte only
                rd_val = {16'h0000, sup ? st_q.status : {8'h00, st_q.status[7:0]}};
            end
            cprm_pkg::sel_vbase: begin
                rd_val = st_q.vbase;
                priv_err = !sup;
            end
            cprm_pkg::sel_sfc: begin
                rd_val = {29'h0, st_q.alt_source_function_code};
                priv_err = !sup;
            end
            cprm_pkg::sel_dfc: begin
                rd_val = {29'h0, st_q.dfc};
                priv_err = !sup;
            end
            cprm_pkg::sel_pc_adv: rd_val = 32'h0000_0000;
            cprm_pkg::sel_exc: rd_val = 32'h0000_0000;
            cprm_pkg::sel_index_cfg: rd_val = {25'h0, st_q.index_cfg};
            cprm_pkg::sel_index_res: begin
                rd_val = idx_res;
                err = pwrite;
            end
            cprm_pkg::sel_quad_cfg: rd_val = {25'h0, st_q.quad_cfg};
            cprm_pkg::sel_quad_hi: begin
                rd_val = gpr_q[{2'b00, st_q.quad_cfg[2:0]}];
                size_err = pwrite && (pstrb != `CPRM_BE_LONG);
            end
            cprm_pkg::sel_quad_lo: begin
                rd_val = gpr_q[{2'b00, st_q.quad_cfg[6:4]}];
                size_err = pwrite && (pstrb != `CPRM_BE_LONG);
            end
            cprm_pkg::sel_bit_op: rd_val = {22'h0, st_q.bit_cfg};
            cprm_pkg::sel_status_copy: begin
                rd_val = {16'h0000, st_q.status};
                priv_err = !sup;
                err = pwrite;
            end
            cprm_pkg::sel_fault: rd_val = {30'h0, st_q.fault};
            default: err = 1'b1;
        endcase
        err = err || priv_err || size_err;
    end

    // next state and write effects
    always_comb begin
        st_d = st_q;
        gpr_we = '0;
        gpr_be = `CPRM_BE_LONG;
        gpr_sext = 1'b0;
        gpr_wd = pwdata;
        if (setup) begin
            st_d.rdata = err ? 32'h0000_0000 : rd_val;
        end
        if (access && pwrite && !err) begin
            case (sel)
                cprm_pkg::sel_data: begin
                    gpr_we[reg_idx] = 1'b1;
                    gpr_be = pstrb;
                end
                cprm_pkg::sel_addr: begin
                    gpr_we[reg_idx] = 1'b1;
                    gpr_be = pstrb;
                    gpr_sext = 1'b1;
                end
                cprm_pkg::sel_stack: begin
                    gpr_we[sup ? `CPRM_IDX_SSP : `CPRM_IDX_USP] = 1'b1;
                    gpr_be = pstrb;
                    gpr_sext = 1'b1;
                end
                cprm_pkg::sel_usp: begin
                    gpr_we[`CPRM_IDX_USP] = 1'b1;
                    gpr_be = pstrb;
                    gpr_sext = 1'b1;
                end
                cprm_pkg::sel_pc: st_d.pc = pwdata;
                cprm_pkg::sel_pc_adv: begin
                    st_d.pc = st_q.pc + {24'h0, pwdata[7:1], 1'b0};
                end
                cprm_pkg::sel_exc: begin
                    // exception entry: vector fetch address, supervisor, no trace
                    st_d.pc = st_q.vbase + {22'h0, pwdata[7:0], 2'b00};
                    st_d.status[`CPRM_SW_T1] = 1'b0;
                    st_d.status[`CPRM_SW_T0] = 1'b0;
                    st_d.status[`CPRM_SW_S] = 1'b1;
                end
                cprm_pkg::sel_status: begin
                    if (sup) begin
                        st_d.status = pwdata[15:0] & `CPRM_STATUS_MASK;
                    end else begin
                        st_d.status[7:0] = pwdata[7:0] & `CPRM_FLAG_MASK;
                    end
                end
                cprm_pkg::sel_vbase: st_d.vbase = pwdata;
                cprm_pkg::sel_sfc: st_d.alt_source_function_code = pwdata[2:0];
                cprm_pkg::sel_dfc: st_d.dfc = pwdata[2:0];
                cprm_pkg::sel_index_cfg: st_d.index_cfg = pwdata[6:0];
                cprm_pkg::sel_quad_cfg: st_d.quad_cfg = pwdata[6:0];
                cprm_pkg::sel_quad_hi: gpr_we[{2'b00, st_q.quad_cfg[2:0]}] = 1'b1;
                cprm_pkg::sel_quad_lo: gpr_we[{2'b00, st_q.quad_cfg[6:4]}] = 1'b1;
                cprm_pkg::sel_bit_op: begin
                    st_d.bit_cfg = pwdata[9:0];
                    st_d.status[`CPRM_SW_Z] = !(|(bit_src & bit_mask));
                    case (cprm_pkg::cprm_bitop_e'(pwdata[9:8]))
                        cprm_pkg::bitop_change: gpr_wd = bit_src ^ bit_mask;
                        cprm_pkg::bitop_clear: gpr_wd = bit_src & ~bit_mask;
                        cprm_pkg::bitop_set: gpr_wd = bit_src | bit_mask;
                        default: gpr_wd = bit_src;
                    endcase
                    gpr_we[bit_reg] = (pwdata[9:8] != 2'b00);
                end
                cprm_pkg::sel_fault: st_d.fault = st_q.fault & ~pwdata[1:0];
                default: st_d.fault = st_d.fault;
            endcase
        end
        // a new refusal wins over a clear in the same access
        if (access && priv_err) begin
            st_d.fault[`CPRM_FAULT_PRIV] = 1'b1;
        end
        if (access && size_err) begin
            st_d.fault[`CPRM_FAULT_SIZE] = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
            st_q.status <= `CPRM_STATUS_RESET;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    // bus answer
    assign pready = ce;
    assign pslverr = access && err;
    assign prdata = st_q.rdata;

    // status view
    assign supervisor = st_q.status[`CPRM_SW_S];
    assign interrupt_priority_mask = st_q.status[`CPRM_SW_IPM_HI:`CPRM_SW_IPM_LO];
    assign trace_mode = st_q.status[`CPRM_SW_T1:`CPRM_SW_T0];
    assign program_counter = st_q.pc;

endmodule : cprm_regfile

// ---- sim/cprm_regfile_monitor.sv ----
// port assertions of the programmer register model
`timescale 1ns/100ps
`include "cprm_defines.svh"

module cprm_monitor (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // status view
    input wire logic supervisor,
    input wire logic [2:0] interrupt_priority_mask,
    input wire logic [1:0] trace_mode,
    input wire logic [31:0] program_counter
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    logic wok;
    assign acc = psel && penable && pready;
    assign wok = acc && pwrite && !pslverr;

    reset_state_a: assert property ($rose(presetn) |->
        supervisor && interrupt_priority_mask == 3'h7 && trace_mode == 2'h0)
        else $error("status view wrong after reset");
    pc_load_a: assert property (wok && paddr == `CPRM_OFF_PC
        |=> program_counter == $past(pwdata)) else $error("pc not loaded");
    pc_advance_a: assert property (wok && paddr == `CPRM_OFF_PC_ADV |=>
        program_counter == $past(program_counter) + {24'h0, $past(pwdata[7:1]), 1'b0})
        else $error("pc not advanced");
    exc_entry_a: assert property (wok && paddr == `CPRM_OFF_EXC
        |=> supervisor && trace_mode == 2'h0) else $error("exception entry state wrong");
    sup_ctrl_refused_a: assert property (acc && !supervisor && paddr inside
        {`CPRM_OFF_VBASE, `CPRM_OFF_SFC, `CPRM_OFF_DFC, `CPRM_OFF_USP} |-> pslverr)
        else $error("control register reached at user level");
    copy_refused_a: assert property (acc && !pwrite && !supervisor
        && paddr == `CPRM_OFF_STATUS_COPY |-> pslverr) else $error("status copy at user level");
    status_write_a: assert property (wok && supervisor && paddr == `CPRM_OFF_STATUS
        |=> {trace_mode, supervisor, interrupt_priority_mask}
        == {$past(pwdata[15:13]), $past(pwdata[10:8])}) else $error("status fields wrong");
    user_status_a: assert property (wok && !supervisor && paddr == `CPRM_OFF_STATUS
        |=> !supervisor && $stable(trace_mode) && $stable(interrupt_priority_mask))
        else $error("user write reached system byte");
    refused_quiet_a: assert property (acc && pslverr
        |=> $stable(program_counter) && $stable(supervisor)) else $error("refused access acted");
    refused_zero_a: assert property (acc && pslverr && !pwrite
        |-> prdata == 32'h0) else $error("refused read returned data");
endmodule : cprm_monitor

bind cprm_regfile cprm_monitor u_mon (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .supervisor(supervisor),
    .interrupt_priority_mask(interrupt_priority_mask), .trace_mode(trace_mode),
    .program_counter(program_counter)
);

// ---- sim/test_cpu_programmer_register_model.sv ----
// self-checking bench of the programmer register model
`timescale 1ns/100ps
`include "cprm_defines.svh"

module test_cpu_programmer_register_model;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic supervisor;
    logic [2:0] interrupt_priority_mask;
    logic [1:0] trace_mode;
    logic [31:0] program_counter;
    logic [31:0] rd;
    logic [31:0] sv;
    logic err;
    int n_mismatch = 0;
    int checks_done = 0;
    int cycles = 0;

    cprm_regfile DUT (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .supervisor(supervisor),
        .interrupt_priority_mask(interrupt_priority_mask), .trace_mode(trace_mode),
        .program_counter(program_counter)
    );
    assign sv = {26'h0, trace_mode, supervisor, interrupt_priority_mask};

    initial begin
        forever #2 pclk = ~pclk;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        xfer(1'b1, a, d, s);
    endtask : wr

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0, 4'hf);
        chk(rd, e);
    endtask : rc

    task automatic t_reset();
        chk(sv, 32'h0f);
        rc(`CPRM_OFF_STATUS, 32'h2700);
        rc(`CPRM_OFF_VBASE, 32'h0);
        rc(8'h80, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_bank();
        wr(`CPRM_OFF_DATA0 + 8'h08, 32'h11223344, 4'hf);
        wr(`CPRM_OFF_DATA0 + 8'h08, 32'h000000aa, 4'h1);
        rc(`CPRM_OFF_DATA0 + 8'h08, 32'h112233aa);
        wr(`CPRM_OFF_DATA0 + 8'h08, 32'h0000beef, 4'h3);
        rc(`CPRM_OFF_DATA0 + 8'h08, 32'h1122beef);
        wr(`CPRM_OFF_DATA0 + 8'h08, 32'h0, 4'h2);
        chk({31'h0, err}, 32'h1);
        wr(`CPRM_OFF_ADDR0 + 8'h04, 32'h00008001, 4'h3);
        rc(`CPRM_OFF_ADDR0 + 8'h04, 32'hffff8001);
        wr(`CPRM_OFF_ADDR0 + 8'h04, 32'h55, 4'h1);
        chk({31'h0, err}, 32'h1);
        wr(`CPRM_OFF_QUAD_CFG, 32'h43, 4'hf);
        wr(`CPRM_OFF_QUAD_HI, 32'hdeadbeef, 4'hf);
        wr(`CPRM_OFF_QUAD_LO, 32'h01234567, 4'hf);
        rc(`CPRM_OFF_DATA0 + 8'h0c, 32'hdeadbeef);
        rc(`CPRM_OFF_DATA0 + 8'h10, 32'h01234567);
        wr(`CPRM_OFF_QUAD_HI, 32'h0, 4'h3);
        chk({31'h0, err}, 32'h1);
        $display("t_bank done");
    endtask : t_bank

    task automatic t_index();
        wr(`CPRM_OFF_INDEX_CFG, 32'h59, 4'hf);
        rc(`CPRM_OFF_INDEX_RES, 32'hfffe0004);
        wr(`CPRM_OFF_INDEX_CFG, 32'h22, 4'hf);
        rc(`CPRM_OFF_INDEX_RES, 32'hffff7dde);
        wr(`CPRM_OFF_INDEX_RES, 32'h0, 4'hf);
        chk({31'h0, err}, 32'h1);
        wr(`CPRM_OFF_BIT_OP, 32'h322, 4'hf);
        rc(`CPRM_OFF_DATA0 + 8'h08, 32'h1122beff);
        rc(`CPRM_OFF_STATUS, 32'h2704);
        $display("t_index done");
    endtask : t_index

    task automatic t_pc();
        wr(`CPRM_OFF_PC, 32'h400, 4'hf);
        @(negedge pclk);
        chk(program_counter, 32'h400);
        // clock enable low in the access phase adds wait states
        fork
            wr(`CPRM_OFF_PC_ADV, 32'h13, 4'hf);
            begin
                repeat (2) @(posedge pclk);
                ce <= 1'b0;
                repeat (2) @(posedge pclk);
                chk({31'h0, pready}, 32'h0);
                chk(program_counter, 32'h400);
                @(posedge pclk);
                ce <= 1'b1;
            end
        join
        rc(`CPRM_OFF_PC, 32'h412);
        $display("t_pc done");
    endtask : t_pc

    task automatic t_priv();
        wr(`CPRM_OFF_VBASE, 32'h100, 4'hf);
        wr(`CPRM_OFF_SFC, 32'h5, 4'hf);
        wr(`CPRM_OFF_DFC, 32'h2, 4'hf);
        rc(`CPRM_OFF_SFC, 32'h5);
        rc(`CPRM_OFF_DFC, 32'h2);
        wr(`CPRM_OFF_STACK, 32'h1000, 4'hf);
        wr(`CPRM_OFF_USP, 32'h2000, 4'hf);
        wr(`CPRM_OFF_FAULT, 32'h3, 4'hf);
        wr(`CPRM_OFF_STATUS, 32'hffff, 4'hf);
        rc(`CPRM_OFF_STATUS, 32'he71f);
        wr(`CPRM_OFF_STATUS, 32'hc000, 4'hf);
        @(negedge pclk);
        chk(sv, 32'h30);
        rc(`CPRM_OFF_STACK, 32'h2000);
        wr(`CPRM_OFF_STATUS, 32'hffff, 4'hf);
        rc(`CPRM_OFF_STATUS, 32'h1f);
        chk(sv, 32'h30);
        rc(`CPRM_OFF_USP, 32'h0);
        chk({31'h0, err}, 32'h1);
        rc(`CPRM_OFF_STATUS_COPY, 32'h0);
        chk({31'h0, err}, 32'h1);
        rc(`CPRM_OFF_DFC, 32'h0);
        chk({31'h0, err}, 32'h1);
        rc(`CPRM_OFF_FAULT, 32'h1);
        wr(`CPRM_OFF_EXC, 32'h2, 4'hf);
        @(negedge pclk);
        chk(program_counter, 32'h108);
        chk(sv, 32'h08);
        rc(`CPRM_OFF_STACK, 32'h1000);
        rc(`CPRM_OFF_STATUS_COPY, 32'h201f);
        $display("t_priv done");
    endtask : t_priv

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_bank();
        t_index();
        t_pc();
        t_priv();
        tally_and_finish();
    end
endmodule : test_cpu_programmer_register_model
